// ### core/amp_diag_pkg.sv
// constants, field layouts and types for the amplifier diagnostic serial target
// assumes a single core clock domain plus the serial link clock domain
`default_nettype none
package amp_diag_pkg;
  // ==========================================================
  // sizes and counts
  localparam int NUM_CH = 4;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [1:0] RD_FIRST = 2'h0;
  // ==========================================================
  // addressing; the target address default is arbitrary
  localparam logic [6:0] TARGET_ADDR_DEF = 7'h6C;
  localparam int SUB_AUTOINC_BIT = 7;
  localparam logic [6:0] SUB_CTRL_ONE = 7'h01;
  localparam logic [6:0] SUB_CTRL_TWO = 7'h02;
  // ==========================================================
  // control byte fields
  localparam int C1_DIAG_EN = 6;
  localparam int C1_OFFSET_EN = 5;
  localparam int C2_THRESH_HI = 7;
  localparam int C2_STBY_OFF = 4;
  localparam int C2_CUR_EN = 2;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  // ==========================================================
  // status byte fields
  localparam int SB_HI = 7;
  localparam int SB_MID = 6;
  localparam int SB_CUR = 5;
  localparam int SB_PERM = 4;
  localparam int SB_SHORT = 3;
  localparam int SB_OPEN = 2;
  localparam int SB_SVCC = 1;
  localparam int SB_SGND = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [1:0] UNUSED_HI = 2'h0;
  // ==========================================================
  // types
  typedef struct packed {
    logic below_250;
    logic below_100;
    logic above_500;
    logic above_300;
    logic permanent;
    logic short_load;
    logic open_load;
    logic offset;
    logic short_vcc;
    logic short_gnd;
  } chan_diag_s;
  typedef struct packed {
    logic [7:0] two;
    logic [7:0] one;
  } ctrl_pair_s;
  typedef logic [3:0][7:0] status_t;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_SUB = 7'h04,
    ST_WDATA = 7'h08,
    ST_ACK = 7'h10,
    ST_TX = 7'h20,
    ST_TXACK = 7'h40
  } link_state_e;
endpackage
`default_nettype wire

// ### core/amp_diag_i2c_target.sv
// serial-bus target of a four channel amplifier: control bytes in, status bytes out
// assumes an open-drain data line resolved outside, and a bus clock driven by the controller
//
// Notes on behaviour
// RQ1 - status byte two bit 7 shows offset detection active.
// RQ2 - status byte two bit 6 shows current sensor active.
// RQ3 - bit 5 flags open load below selected low threshold, clears above high one.
// RQ4 - bit 5 carries meaning only while current detection is enabled.
// RQ5 - bit 4 gives diagnostic type: turn-on 0, permanent 1.
// RQ6 - bit 3 flags a shorted load.
// RQ7 - bit 2 flags open load, or output offset in offset mode.
// RQ8 - bit 1 flags short to supply, bit 0 short to ground.
// RQ9 - status byte three bit 7 mirrors standby bit of control byte two.
// RQ10 - status byte three bit 6 mirrors diagnostic enable of control byte one.
// RQ11 - turn-on diagnosis starts by writing both control bytes after sub-address.
// RQ12 - both control bytes written in one auto-increment write, each acknowledged.
// RQ13 - read returns status bytes one to four in order after address acknowledge.
// RQ14 - power-up pattern is written by the controller.
// RQ15 - power-down pattern clears standby bit, written by the controller.
// RQ16 - offset procedure pattern is written by the controller.
// RQ17 - after offset detection only bit 2 of each status byte is meaningful.
// RQ18 - controller ends every transaction with a stop.
// RQ19 - control byte two bit 7 selects the current threshold set.
// RQ20 - control byte two bit 2 enables current detection flags.
// RQ21 - sub-address top bit set means auto increment.
// RQ22 - controller ends a read with not-acknowledge, else data line stays held.
// RQ23 - status byte four bits 7 and 6 read as zero.
`default_nettype none
module amp_diag_i2c_target
  import amp_diag_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEF
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic LINK_SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire chan_diag_s [NUM_CH-1:0] DIAG_IN,
  input wire logic THERMAL_WARN,
  input wire logic DIAG_DONE,
  output logic [7:0] CTRL_ONE,
  output logic [7:0] CTRL_TWO
);

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // input synchronisers
  chan_diag_s [NUM_CH-1:0] diag_meta;
  chan_diag_s [NUM_CH-1:0] diag_q;
  logic therm_meta;
  logic therm_q;
  logic done_meta;
  logic done_q;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      diag_meta <= '0;
      diag_q <= '0;
      therm_meta <= 1'b0;
      therm_q <= 1'b0;
      done_meta <= 1'b0;
      done_q <= 1'b0;
    end else begin
      diag_meta <= DIAG_IN;
      diag_q <= diag_meta;
      therm_meta <= THERMAL_WARN;
      therm_q <= therm_meta;
      done_meta <= DIAG_DONE;
      done_q <= done_meta;
    end
  end

  // ==========================================================
  // control bytes, core copy
  ctrl_pair_s link_ctrl;
  logic wr_tgl;
  logic wr_s1;
  logic wr_s2;
  logic wr_s3;
  logic [7:0] ctrl_one;
  logic [7:0] ctrl_two;

  wire logic wr_seen = wr_s2 ^ wr_s3;

  // link copy is stable for a whole byte time, far longer than this sync path
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_s1 <= 1'b0;
      wr_s2 <= 1'b0;
      wr_s3 <= 1'b0;
      ctrl_one <= CTRL_ONE_RST;
      ctrl_two <= CTRL_TWO_RST;
    end else begin
      wr_s1 <= wr_tgl;
      wr_s2 <= wr_s1;
      wr_s3 <= wr_s2;
      if (wr_seen) begin
        ctrl_one <= link_ctrl.one;
        ctrl_two <= link_ctrl.two;
      end
    end
  end

  assign CTRL_ONE = ctrl_one;
  assign CTRL_TWO = ctrl_two;

  wire logic cur_en = ctrl_two[C2_CUR_EN]; // RQ20
  wire logic thr_hi = ctrl_two[C2_THRESH_HI];
  wire logic offs_en = ctrl_one[C1_OFFSET_EN];

  // ==========================================================
  // per channel diagnostic bits
  function automatic logic [5:0] chan_bits(input chan_diag_s d, input logic cur,
                                           input logic offs);
    chan_bits = {cur, d.permanent, d.short_load, offs ? d.offset : d.open_load, // RQ6 RQ7 RQ17
                 d.short_vcc, d.short_gnd}; // RQ8
  endfunction

  logic [NUM_CH-1:0] cur_flag;
  logic [NUM_CH-1:0] next_cur;
  logic [NUM_CH-1:0][5:0] low6;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    wire logic below = thr_hi ? diag_q[c].below_100 : diag_q[c].below_250; // RQ19
    wire logic above = thr_hi ? diag_q[c].above_300 : diag_q[c].above_500; // RQ19
    // between thresholds the last verdict holds
    assign next_cur[c] = !cur_en ? 1'b0 : below ? 1'b1 : above ? 1'b0 : cur_flag[c]; // RQ3
    assign low6[c] = chan_bits(diag_q[c], cur_flag[c], offs_en); // RQ5
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cur_flag <= '0;
    end else begin
      cur_flag <= next_cur; // RQ4
    end
  end

  // ==========================================================
  // status bytes
  logic [7:0] status_byte_one;
  logic [7:0] diag_status_ch2;
  logic [7:0] diag_status_ch3;
  logic [7:0] diag_status_ch4;

  wire logic [7:0] next_b1 = {therm_q, done_q, low6[0]};
  wire logic [7:0] next_b2 = {offs_en, cur_en, low6[1]}; // RQ1
  wire logic [7:0] next_b3 = {ctrl_two[C2_STBY_OFF], ctrl_one[C1_DIAG_EN], low6[2]}; // RQ9
  wire logic [7:0] next_b4 = {UNUSED_HI, low6[3]}; // RQ23

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      status_byte_one <= STATUS_RST;
      diag_status_ch2 <= STATUS_RST;
      diag_status_ch3 <= STATUS_RST;
      diag_status_ch4 <= STATUS_RST;
    end else begin
      status_byte_one <= next_b1;
      diag_status_ch2 <= next_b2; // RQ2
      diag_status_ch3 <= next_b3; // RQ10
      diag_status_ch4 <= next_b4;
    end
  end

  // ==========================================================
  // status handover to the link, toggle handshake
  status_t stat_hold;
  logic stat_req;
  logic stat_ack;
  logic ack_s1;
  logic ack_s2;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      stat_hold <= '0;
      stat_req <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= stat_ack;
      ack_s2 <= ack_s1;
      // hold only changes once the link has taken the previous snapshot
      if (ack_s2 == stat_req) begin
        stat_hold <= {diag_status_ch4, diag_status_ch3, diag_status_ch2, status_byte_one};
        stat_req <= ~stat_req;
      end
    end
  end

  // ==========================================================
  // link domain, rising edge: sample data line, take status snapshot
  logic sda_r;
  logic req_s1;
  logic req_s2;
  status_t stat_link;

  // bus clock may stop between frames; the snapshot is simply refreshed in the next one
  always_ff @(posedge LINK_SCL or negedge rst_n) begin
    if (!rst_n) begin
      sda_r <= 1'b1;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      stat_ack <= 1'b0;
      stat_link <= '0;
    end else begin
      sda_r <= SDA_IN;
      req_s1 <= stat_req;
      req_s2 <= req_s1;
      if (req_s2 != stat_ack) begin
        stat_link <= stat_hold;
        stat_ack <= req_s2;
      end
    end
  end

  // ==========================================================
  // link domain, falling edge: byte engine
  link_state_e state;
  link_state_e after;
  logic [2:0] cnt;
  logic [7:0] shreg;
  logic oe;
  logic [6:0] sub_idx;
  logic auto_inc;
  logic [1:0] rd_idx;

  logic stop_tgl;
  logic stop_ack;

  // a rise of the data line with the clock high is a stop; the clock then stands high,
  // so the next start never shows the line high at a rising edge
  always_ff @(posedge SDA_IN or negedge rst_n) begin
    if (!rst_n) begin
      stop_tgl <= 1'b0;
    end else if (LINK_SCL) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  always_ff @(negedge LINK_SCL or negedge rst_n) begin
    if (!rst_n) begin
      stop_ack <= 1'b0;
    end else begin
      stop_ack <= stop_tgl;
    end
  end

  // line low at a falling edge after being high while the clock was high: a start
  wire logic start = (sda_r | (stop_tgl ^ stop_ack)) & ~SDA_IN;
  wire logic [7:0] rx_byte = {shreg[6:0], sda_r};
  wire logic byte_done = (cnt == BYTE_LAST);
  wire logic addr_hit = (rx_byte[7:1] == TARGET_ADDR);
  wire logic [7:0] tx_byte = stat_link[rd_idx];

  always_ff @(negedge LINK_SCL or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      after <= ST_IDLE;
      cnt <= 3'h0;
      shreg <= 8'h00;
      oe <= 1'b0;
      sub_idx <= 7'h00;
      auto_inc <= 1'b0;
      rd_idx <= RD_FIRST;
      link_ctrl <= {CTRL_TWO_RST, CTRL_ONE_RST};
      wr_tgl <= 1'b0;
    end else if (start) begin
      state <= ST_ADDR; // RQ18
      cnt <= 3'h0;
      oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR: begin
          shreg <= rx_byte;
          cnt <= cnt + 3'h1;
          if (byte_done && addr_hit) begin
            oe <= 1'b1;
            state <= ST_ACK;
            after <= rx_byte[0] ? ST_TX : ST_SUB;
            rd_idx <= RD_FIRST; // RQ13
          end else if (byte_done) begin
            state <= ST_IDLE;
          end
        end
        ST_SUB: begin
          shreg <= rx_byte;
          cnt <= cnt + 3'h1;
          if (byte_done) begin
            sub_idx <= rx_byte[6:0];
            auto_inc <= rx_byte[SUB_AUTOINC_BIT]; // RQ21
            oe <= 1'b1;
            state <= ST_ACK;
            after <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          shreg <= rx_byte;
          cnt <= cnt + 3'h1;
          if (byte_done) begin
            if (sub_idx == SUB_CTRL_ONE) begin
              link_ctrl.one <= rx_byte; // RQ11
            end
            if (sub_idx == SUB_CTRL_TWO) begin
              link_ctrl.two <= rx_byte; // RQ12
            end
            if (auto_inc) begin
              sub_idx <= sub_idx + 7'h01; // RQ21
            end
            wr_tgl <= ~wr_tgl;
            oe <= 1'b1; // RQ12
            state <= ST_ACK;
            after <= ST_WDATA;
          end
        end
        ST_ACK: begin
          cnt <= 3'h0;
          if (after == ST_TX) begin
            shreg <= tx_byte;
            oe <= ~tx_byte[7];
            rd_idx <= rd_idx + 2'h1; // RQ13
            state <= ST_TX;
          end else begin
            oe <= 1'b0;
            state <= after;
          end
        end
        ST_TX: begin
          if (byte_done) begin
            oe <= 1'b0;
            state <= ST_TXACK;
          end else begin
            shreg <= {shreg[6:0], 1'b0};
            oe <= ~shreg[6];
            cnt <= cnt + 3'h1;
          end
        end
        ST_TXACK: begin
          cnt <= 3'h0;
          if (!sda_r) begin
            // acknowledged: keep going, wrapping after byte four
            shreg <= tx_byte;
            oe <= ~tx_byte[7];
            rd_idx <= rd_idx + 2'h1;
            state <= ST_TX;
          end else begin
            state <= ST_IDLE; // RQ22
          end
        end
        ST_IDLE: begin
          oe <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          oe <= 1'b0;
        end
      endcase
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe;

  // ==========================================================
  // assertions
  property p_offset_bit;
    @(posedge CORE_CLK) disable iff (!rst_n) offs_en |=> diag_status_ch2[SB_HI];
  endproperty
  a_offset_bit: assert property (p_offset_bit) else $error("offset bit not set"); // RQ1

  property p_sensor_bit;
    @(posedge CORE_CLK) disable iff (!rst_n) $fell(cur_en) |=> !diag_status_ch2[SB_MID];
  endproperty
  a_sensor_bit: assert property (p_sensor_bit) else $error("sensor bit stuck"); // RQ2

  property p_open_low;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (cur_en && !thr_hi && diag_q[1].below_250) |=> ##1 diag_status_ch2[SB_CUR];
  endproperty
  a_open_low: assert property (p_open_low) else $error("open load missed"); // RQ3

  property p_normal_hi;
    @(posedge CORE_CLK) disable iff (!rst_n)
      (cur_en && thr_hi && diag_q[2].above_300 && !diag_q[2].below_100)
        |=> ##1 !diag_status_ch3[SB_CUR];
  endproperty
  a_normal_hi: assert property (p_normal_hi) else $error("normal load missed"); // RQ3

  property p_cur_off;
    @(posedge CORE_CLK) disable iff (!rst_n) !cur_en [*2] |=> !diag_status_ch4[SB_CUR];
  endproperty
  a_cur_off: assert property (p_cur_off) else $error("current flag while off"); // RQ4

  property p_type_bit;
    @(posedge CORE_CLK) disable iff (!rst_n)
      diag_status_ch2[SB_PERM] == $past(diag_q[1].permanent);
  endproperty
  a_type_bit: assert property (p_type_bit) else $error("type bit wrong"); // RQ5

  property p_short_bit;
    @(posedge CORE_CLK) disable iff (!rst_n)
      $rose(diag_q[3].short_load) |-> ##1 diag_status_ch4[SB_SHORT];
  endproperty
  a_short_bit: assert property (p_short_bit) else $error("short load missed"); // RQ6

  property p_open_mux;
    @(posedge CORE_CLK) disable iff (!rst_n)
      diag_status_ch3[SB_OPEN] == ($past(offs_en) ? $past(diag_q[2].offset)
                                                   : $past(diag_q[2].open_load));
  endproperty
  a_open_mux: assert property (p_open_mux) else $error("bit two source wrong"); // RQ7

  property p_supply_gnd;
    @(posedge CORE_CLK) disable iff (!rst_n)
      diag_status_ch2[SB_SVCC:SB_SGND] ==
        {$past(diag_q[1].short_vcc), $past(diag_q[1].short_gnd)};
  endproperty
  a_supply_gnd: assert property (p_supply_gnd) else $error("short flags wrong"); // RQ8

  property p_stby_mirror;
    @(posedge CORE_CLK) disable iff (!rst_n)
      $changed(ctrl_two[C2_STBY_OFF]) |=> diag_status_ch3[SB_HI] == ctrl_two[C2_STBY_OFF];
  endproperty
  a_stby_mirror: assert property (p_stby_mirror) else $error("standby mirror wrong"); // RQ9

  property p_diag_mirror;
    @(posedge CORE_CLK) disable iff (!rst_n)
      ctrl_one[C1_DIAG_EN] [*2] |-> diag_status_ch3[SB_MID];
  endproperty
  a_diag_mirror: assert property (p_diag_mirror) else $error("diag mirror wrong"); // RQ10

  property p_top_zero;
    @(posedge CORE_CLK) disable iff (!rst_n) diag_status_ch4[SB_HI:SB_MID] == UNUSED_HI;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("byte four top bits set"); // RQ23

  property p_ack_drive;
    @(negedge LINK_SCL) disable iff (!rst_n)
      (state == ST_WDATA && byte_done && !start) |=> (state == ST_ACK && oe);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("data byte not acknowledged"); // RQ12

  property p_read_first;
    @(negedge LINK_SCL) disable iff (!rst_n)
      (state == ST_ADDR && byte_done && addr_hit && sda_r && !start)
        |=> ##1 (state == ST_TX && rd_idx == 2'h1);
  endproperty
  a_read_first: assert property (p_read_first) else $error("read did not start"); // RQ13

  property p_nack_end;
    @(negedge LINK_SCL) disable iff (!rst_n)
      (state == ST_TXACK && sda_r && !start) |=> (state == ST_IDLE && !oe);
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("line held after nack"); // RQ22

  c_ctrl_write: cover property (@(posedge CORE_CLK) disable iff (!rst_n) wr_seen);
  c_next_byte: cover property (@(negedge LINK_SCL) disable iff (!rst_n)
    state == ST_TXACK && !sda_r);
  c_offset_on: cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    diag_status_ch2[SB_HI] && diag_status_ch2[SB_OPEN]);

endmodule // amp_diag_i2c_target
`default_nettype wire

// ### testbench/bus_ctl_model.sv
// bus controller model: makes the serial clock and pulls the data line low
// assumes the data line is resolved outside with a pull-up; clock idles high
`default_nettype none
module bus_ctl_model
  import amp_diag_pkg::*;
(
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // bit level, 48 ns period; data bits move only while the clock is low, start and stop move it with the clock high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bit_out(input logic b);
    #12 sda_low = ~b;
    #12 scl = 1'b1;
    #24 scl = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    #12 sda_low = 1'b0;
    #12 scl = 1'b1;
    b = sda;
    #24 scl = 1'b0;
  endtask
  task automatic start_cond();
    #12 sda_low = 1'b0;
    #12 scl = 1'b1;
    #24 sda_low = 1'b1;
    #24 scl = 1'b0;
  endtask
  // clock then stands high until the next frame
  task automatic stop_cond();
    #12 sda_low = 1'b1;
    #12 scl = 1'b1;
    #24 sda_low = 1'b0;
    #24;
  endtask
  // ==========================================================
  // byte level
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(a);
    ack = ~a;
  endtask
  task automatic byte_in(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(~ack);
  endtask
  // ==========================================================
  // frames
  task automatic write2(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] b1,
      input logic [7:0] b2, output logic [3:0] acks);
    start_cond();
    byte_out({a, 1'b0}, acks[0]);
    byte_out(sub, acks[1]);
    byte_out(b1, acks[2]);
    byte_out(b2, acks[3]);
    stop_cond();
  endtask
  task automatic read4(input logic [6:0] a, output logic ack, output status_t d);
    start_cond();
    byte_out({a, 1'b1}, ack);
    for (int i = 0; i < 4; i++) begin
      byte_in(i < 3, d[i]);
    end
    stop_cond();
  endtask
endmodule // bus_ctl_model
`default_nettype wire

// ### testbench/test_amp_diag_i2c_target.sv
// self-checking bench: control bytes written and status bytes read over the serial bus
// assumes the bus controller model and a pulled-up data line
`default_nettype none
module test_amp_diag_i2c_target
  import amp_diag_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADDR = TARGET_ADDR_DEF;
  localparam int LIMIT = 20000;
  logic core_clk;
  logic rst_b;
  logic scl;
  logic sda_low;
  logic sda_oe;
  logic sda_out;
  logic thermal;
  logic done;
  chan_diag_s [NUM_CH-1:0] diag;
  logic [7:0] ctrl_one;
  logic [7:0] ctrl_two;
  logic [7:0] e1;
  logic [7:0] e2;
  logic [3:0] acks;
  logic ack;
  status_t rd;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  // low if either party pulls, pull-up otherwise
  wire logic sda_line = ~(sda_low | (sda_oe & ~sda_out));
  // ==========================================================
  // clock, parts
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  amp_diag_i2c_target dut (
    .CORE_CLK(core_clk),
    .RST_B(rst_b),
    .LINK_SCL(scl),
    .SDA_IN(sda_line),
    .SDA_OUT(sda_out),
    .SDA_OE(sda_oe),
    .DIAG_IN(diag),
    .THERMAL_WARN(thermal),
    .DIAG_DONE(done),
    .CTRL_ONE(ctrl_one),
    .CTRL_TWO(ctrl_two)
  );
  bus_ctl_model ctl (
    .scl(scl),
    .sda_low(sda_low),
    .sda(sda_line)
  );
  // ==========================================================
  // checking and reporting
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("ERROR timeout expected finish seen hang");
      complete_run();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ==========================================================
  // expected status bits of one channel; below and above are kept opposite
  function automatic logic [5:0] chan_bits(input int c);
    logic cur;
    cur = e2[C2_CUR_EN] & (e2[C2_THRESH_HI] ? diag[c].below_100 : diag[c].below_250);
    return {cur, diag[c].permanent, diag[c].short_load,
      e1[C1_OFFSET_EN] ? diag[c].offset : diag[c].open_load,
      diag[c].short_vcc, diag[c].short_gnd};
  endfunction
  task automatic set_diag(input logic [5:0] base, input logic tw, input logic dd);
    logic [5:0] v;
    @(posedge core_clk);
    for (int c = 0; c < NUM_CH; c++) begin
      v = base + 6'(c * 11);
      diag[c] <= '{v[5], v[0] ^ v[5], ~v[5], ~(v[0] ^ v[5]), v[4], v[3], v[2], ~v[2],
        v[1], v[0]};
    end
    thermal <= tw;
    done <= dd;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic wr(input string tname, input logic [6:0] a, input logic [7:0] sub,
      input logic [7:0] b1, input logic [7:0] b2, input logic [3:0] eacks);
    ctl.write2(a, sub, b1, b2, acks);
    repeat (10) @(posedge core_clk);
    check({tname, " acks"}, {4'h0, acks}, {4'h0, eacks});
    check({tname, " ctrl one"}, ctrl_one, e1);
    check({tname, " ctrl two"}, ctrl_two, e2);
    $display("write %s done", tname);
  endtask
  // first read only refreshes the snapshot, which lags by a few bus clocks
  task automatic rd_status(input string tname);
    status_t ex;
    ex[0] = {thermal, done, chan_bits(0)};
    ex[1] = {e1[C1_OFFSET_EN], e2[C2_CUR_EN], chan_bits(1)};
    ex[2] = {e2[C2_STBY_OFF], e1[C1_DIAG_EN], chan_bits(2)};
    ex[3] = {2'h0, chan_bits(3)};
    repeat (2) ctl.read4(ADDR, ack, rd);
    check({tname, " addr ack"}, {7'h00, ack}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      check($sformatf("%s byte %0d", tname, i + 1), rd[i], ex[i]);
    end
    check({tname, " released"}, {7'h00, sda_oe}, 8'h00);
    $display("read %s done", tname);
  endtask
  // ==========================================================
  // sequence
  initial begin
    rst_b = 1'b0;
    thermal = 1'b0;
    done = 1'b0;
    diag = '0;
    e1 = CTRL_ONE_RST;
    e2 = CTRL_TWO_RST;
    repeat (16) @(posedge core_clk);
    check("reset ctrl one", ctrl_one, 8'h00);
    check("reset ctrl two", ctrl_two, 8'h00);
    check("reset data drive", {7'h00, sda_oe}, 8'h00);
    rst_b <= 1'b1;
    repeat (8) @(posedge core_clk);
    set_diag(6'h15, 1'b1, 1'b0);
    e2 = 8'h10;
    wr("power_up", ADDR, 8'h81, 8'h00, 8'h10, 4'hF);
    rd_status("power_up");
    e1 = 8'h40;
    e2 = 8'h14;
    wr("turn_on", ADDR, 8'h81, 8'h40, 8'h14, 4'hF);
    rd_status("turn_on");
    set_diag(6'h2A, 1'b0, 1'b1);
    rd_status("new_diag");
    e2 = 8'h94;
    wr("thresh_hi", ADDR, 8'h81, 8'h40, 8'h94, 4'hF);
    rd_status("thresh_hi");
    e2 = 8'h10;
    wr("cur_off", ADDR, 8'h81, 8'h40, 8'h10, 4'hF);
    rd_status("cur_off");
    e1 = 8'h26;
    wr("offset", ADDR, 8'h81, 8'h26, 8'h10, 4'hF);
    rd_status("offset");
    e1 = 8'h00;
    e2 = 8'h00;
    wr("power_off", ADDR, 8'h81, 8'h00, 8'h00, 4'hF);
    rd_status("power_off");
    e2 = 8'h5A;
    wr("no_autoinc", ADDR, 8'h02, 8'hA5, 8'h5A, 4'hF);
    wr("bad_sub", ADDR, 8'h05, 8'hFF, 8'hFF, 4'hF);
    wr("wrong_addr", ADDR ^ 7'h01, 8'h81, 8'hFF, 8'hFF, 4'h0);
    complete_run();
  end
endmodule // test_amp_diag_i2c_target
`default_nettype wire
